// >>> pdt_pkg.sv
// What this block does
// - rising trigger pulse starts a timing cycle
// - trigger enables counter, outputs low, starts time base unless ext_clk_sel
// - time base gives one short low tick per period
// - counter counts ticks, binary or bcd digits
// - rising reset pulse ends the timing cycle
// - reset: all disabled, outputs and carry high
// - feedback of summed bus self-resets at programmed count
// - without feedback counting runs free until reset
// - summed bus low while any selected output low
// - binary weights 1 to 128, sixth gives 32
// - decimal weights 1,2,4,8,10,20,40,80; sixth gives 20
// - cycle spans 1-255, 1-99 or 1-59 ticks
// - decimal digit codes ten or more never match
// - sixty variant: tens 0 to 5, seven outputs
// - carry chains two decimal stages up to 9999
// - power-up enters the reset state
// - running cycle ignores further trigger pulses
// - trigger wins over simultaneous reset
// - decimal carry high for last ten counts
// - count on falling count clock; low freezes
package pdt_pkg;

	// ****************************************
	// variants and states
	// ****************************************
	localparam logic [1:0] VAR_BIN   = 2'h0;
	localparam logic [1:0] VAR_DEC99 = 2'h1;
	localparam logic [1:0] VAR_DEC59 = 2'h2;

	typedef enum logic {PDT_IDLE, PDT_RUN} pdt_state_e;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned TB_PERIOD_NS  = 1000;
	localparam int unsigned TB_PERIOD_CYC =
		(TB_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// counter layout and reset values
	// ****************************************
	localparam int unsigned CNT_W      = 8;
	localparam int unsigned UNIT_LSB   = 0;
	localparam int unsigned TENS_LSB   = 4;
	localparam logic [3:0]  DIGIT_MAX  = 4'h9;
	localparam logic [3:0]  TENS59_MAX = 4'h5;
	localparam logic [7:0]  CNT_RST    = 8'h00;
	localparam logic [7:0]  OE_RST     = 8'h00;
	localparam logic [7:0]  MASK_8     = 8'hff;
	localparam logic [7:0]  MASK_7     = 8'h7f;

	// ****************************************
	// synchroniser vector positions
	// ****************************************
	localparam int unsigned SY_TRIG = 0;
	localparam int unsigned SY_RST  = 1;
	localparam int unsigned SY_EXT  = 2;
	localparam int unsigned SY_XSEL = 3;
	localparam int unsigned SY_FB   = 4;
	localparam int unsigned SY_SEL  = 5;
	localparam int unsigned SY_W    = 13;

endpackage

// >>> pdt_tb_if.sv
`timescale 1ns/1ps
interface pdt_tb_if;
	logic run;
	logic tick_n;
	modport tb  (input run, output tick_n);
	modport ctl (output run, input tick_n);
endinterface

// >>> pdt_timebase.sv
`timescale 1ns/1ps
module pdt_timebase #(
	parameter int unsigned TB_CYC = pdt_pkg::TB_PERIOD_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	pdt_tb_if.tb     tb
);
	localparam int unsigned     TBW     = $clog2(TB_CYC + 1);
	localparam logic [TBW-1:0]  TB_LAST = TBW'(TB_CYC - 1);

	logic [TBW-1:0] div_q;
	logic [TBW-1:0] div_d;
	logic           tick_n_q;
	logic           tick_n_d;

	// ****************************************
	// period divider, one low tick per period
	// ****************************************
	always_comb begin
		div_d    = '0;
		tick_n_d = 1'b1;
		if (tb.run) begin
			if (div_q == TB_LAST) begin
				tick_n_d = 1'b0;
			end else begin
				div_d = div_q + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q    <= '0;
			tick_n_q <= 1'b1;
		end else begin
			div_q    <= div_d;
			tick_n_q <= tick_n_d;
		end
	end

	assign tb.tick_n = tick_n_q;

endmodule // pdt_timebase

// >>> pdt_top.sv
`timescale 1ns/1ps
module pdt_top #(
	parameter logic [1:0]  VARIANT = pdt_pkg::VAR_DEC99,
	parameter int unsigned TB_CYC  = pdt_pkg::TB_PERIOD_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       trig_pin,
	input  wire logic       reset_pin,
	input  wire logic       ext_clk_pin,
	input  wire logic       ext_clk_sel,
	input  wire logic       fb_en,
	input  wire logic [7:0] prog_sel,
	output logic      [7:0] cnt_o,
	output logic      [7:0] cnt_oe,
	output logic            sum_bus,
	output logic            carry_out,
	output logic            tb_out_n
);
	localparam logic [7:0] OUT_MASK =
		(VARIANT == pdt_pkg::VAR_DEC59) ? pdt_pkg::MASK_7 : pdt_pkg::MASK_8;
	localparam logic [3:0] TENS_MAX =
		(VARIANT == pdt_pkg::VAR_DEC59) ? pdt_pkg::TENS59_MAX : pdt_pkg::DIGIT_MAX;
	localparam logic       IS_BIN   = (VARIANT == pdt_pkg::VAR_BIN);

	// ****************************************
	// declarations
	// ****************************************
	logic [pdt_pkg::SY_W-1:0] sy1_q;
	logic [pdt_pkg::SY_W-1:0] sy2_q;
	logic [pdt_pkg::SY_W-1:0] sy2_d;
	logic                     trig_prev_q;
	logic                     rst_prev_q;
	logic                     ext_prev_q;
	pdt_pkg::pdt_state_e      state_q;
	pdt_pkg::pdt_state_e      state_d;
	logic [7:0]               cnt_q;
	logic [7:0]               cnt_d;
	logic [7:0]               oe_q;
	logic [7:0]               oe_d;
	logic                     bus_q;
	logic                     bus_d;
	logic                     carry_q;
	logic                     carry_d;
	logic                     trig_rise;
	logic                     rst_rise;
	logic                     cnt_evt;
	logic                     self_rst;
	logic                     start;
	logic [7:0]               sel_s;
	logic [7:0]               cnt_nxt;

	pdt_tb_if tbi ();

	pdt_timebase #(
		.TB_CYC (TB_CYC)
	) u_timebase (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tb      (tbi.tb)
	);

	// ****************************************
	// counter step
	// ****************************************
	function automatic logic [7:0] pdt_next(input logic [7:0] c);
		logic [3:0] u;
		logic [3:0] t;
		u = c[pdt_pkg::UNIT_LSB +: 4];
		t = c[pdt_pkg::TENS_LSB +: 4];
		if (IS_BIN) begin
			pdt_next = c + 8'h01;
		end else if (u == pdt_pkg::DIGIT_MAX) begin
			u = 4'h0;
			t = (t == TENS_MAX) ? 4'h0 : t + 4'h1;
			pdt_next = {t, u};
		end else begin
			pdt_next = {t, u + 4'h1};
		end
	endfunction

	// ****************************************
	// pin synchronisers and edge detect
	// ****************************************
	always_comb begin
		sy2_d = sy1_q;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sy1_q       <= '0;
			sy2_q       <= '0;
			trig_prev_q <= 1'b0;
			rst_prev_q  <= 1'b0;
			ext_prev_q  <= 1'b0;
		end else begin
			sy1_q       <= {prog_sel, fb_en, ext_clk_sel, ext_clk_pin, reset_pin, trig_pin};
			sy2_q       <= sy2_d;
			trig_prev_q <= sy2_q[pdt_pkg::SY_TRIG];
			rst_prev_q  <= sy2_q[pdt_pkg::SY_RST];
			ext_prev_q  <= sy2_q[pdt_pkg::SY_EXT];
		end
	end

	assign sel_s     = sy2_q[pdt_pkg::SY_SEL +: 8];
	assign trig_rise = sy2_q[pdt_pkg::SY_TRIG] & ~trig_prev_q;
	assign rst_rise  = sy2_q[pdt_pkg::SY_RST] & ~rst_prev_q;

	// falling edge of the selected count clock
	assign cnt_evt = sy2_q[pdt_pkg::SY_XSEL] ?
		(ext_prev_q & ~sy2_q[pdt_pkg::SY_EXT]) : ~tbi.tick_n;

	// time base stops in the very cycle the cycle ends, so no tick reaches idle
	assign tbi.run = (state_q == pdt_pkg::PDT_RUN) & (state_d == pdt_pkg::PDT_RUN)
		& ~sy2_q[pdt_pkg::SY_XSEL];

	// summed bus high once every selected bit is one
	assign self_rst = (state_q == pdt_pkg::PDT_RUN) & sy2_q[pdt_pkg::SY_FB] & (|sel_s)
		& (&(~sel_s | (cnt_q & OUT_MASK)));

	assign start = trig_rise &
		((state_q == pdt_pkg::PDT_IDLE) | rst_rise | self_rst);

	assign cnt_nxt = pdt_next(cnt_q);

	// ****************************************
	// cycle control and counter
	// ****************************************
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		if (start) begin
			state_d = pdt_pkg::PDT_RUN;
			cnt_d   = pdt_pkg::CNT_RST;
		end else if (rst_rise || self_rst) begin
			state_d = pdt_pkg::PDT_IDLE;
			cnt_d   = pdt_pkg::CNT_RST;
		end else if (state_q == pdt_pkg::PDT_RUN && cnt_evt) begin
			cnt_d   = cnt_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	always_comb begin
		oe_d    = pdt_pkg::OE_RST;
		bus_d   = 1'b1;
		carry_d = 1'b1;
		case (state_d)
			pdt_pkg::PDT_IDLE: begin
				oe_d    = pdt_pkg::OE_RST;
				bus_d   = 1'b1;
				carry_d = 1'b1;
			end
			pdt_pkg::PDT_RUN: begin
				oe_d    = ~cnt_d & OUT_MASK;
				bus_d   = &(~sel_s | (cnt_d & OUT_MASK));
				carry_d = IS_BIN |
					(cnt_d[pdt_pkg::TENS_LSB +: 4] == TENS_MAX);
			end
			default: begin
				oe_d    = pdt_pkg::OE_RST;
				bus_d   = 1'b1;
				carry_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= pdt_pkg::PDT_IDLE;
			cnt_q   <= pdt_pkg::CNT_RST;
			oe_q    <= pdt_pkg::OE_RST;
			bus_q   <= 1'b1;
			carry_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			oe_q    <= oe_d;
			bus_q   <= bus_d;
			carry_q <= carry_d;
		end
	end

	assign cnt_o     = pdt_pkg::OE_RST;
	assign cnt_oe    = oe_q;
	assign sum_bus   = bus_q;
	assign carry_out = carry_q;
	assign tb_out_n  = tbi.tick_n;

	// ****************************************
	// assertions
	// ****************************************
	property p_trig_start;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_q == pdt_pkg::PDT_IDLE && trig_rise)
			|=> (state_q == pdt_pkg::PDT_RUN && cnt_q == pdt_pkg::CNT_RST);
	endproperty
	a_trig_start: assert property (p_trig_start)
		else $error("trigger did not start a cleared cycle");

	property p_reset_stop;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_q == pdt_pkg::PDT_RUN && rst_rise && !trig_rise)
			|=> (state_q == pdt_pkg::PDT_IDLE && cnt_oe == pdt_pkg::OE_RST);
	endproperty
	a_reset_stop: assert property (p_reset_stop)
		else $error("reset pulse did not end the cycle");

	property p_idle_outputs;
		@(posedge sys_clk) disable iff (!rst_n)
		state_q == pdt_pkg::PDT_IDLE
			|-> (cnt_oe == pdt_pkg::OE_RST && carry_out && sum_bus && tb_out_n);
	endproperty
	a_idle_outputs: assert property (p_idle_outputs)
		else $error("outputs not all high in reset state");

	property p_run_outputs;
		@(posedge sys_clk) disable iff (!rst_n)
		state_q == pdt_pkg::PDT_RUN |-> cnt_oe == (~cnt_q & OUT_MASK);
	endproperty
	a_run_outputs: assert property (p_run_outputs)
		else $error("output level does not follow counter bit");

	property p_ignore_trig;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_q == pdt_pkg::PDT_RUN && trig_rise && !rst_rise && !self_rst && !cnt_evt)
			|=> (state_q == pdt_pkg::PDT_RUN && $stable(cnt_q));
	endproperty
	a_ignore_trig: assert property (p_ignore_trig)
		else $error("trigger disturbed a running cycle");

	property p_trig_prio;
		@(posedge sys_clk) disable iff (!rst_n)
		(trig_rise && rst_rise)
			|=> (state_q == pdt_pkg::PDT_RUN && cnt_q == pdt_pkg::CNT_RST);
	endproperty
	a_trig_prio: assert property (p_trig_prio)
		else $error("reset overrode a simultaneous trigger");

	property p_self_rst;
		@(posedge sys_clk) disable iff (!rst_n)
		(self_rst && !trig_rise) |=> state_q == pdt_pkg::PDT_IDLE;
	endproperty
	a_self_rst: assert property (p_self_rst)
		else $error("programmed count did not end the cycle");

	property p_count_step;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_q == pdt_pkg::PDT_RUN && cnt_evt && !rst_rise && !self_rst && !trig_rise)
			|=> cnt_q == $past(cnt_nxt);
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("counter did not advance on count clock");

	property p_freeze;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_q == pdt_pkg::PDT_RUN && !cnt_evt && !rst_rise && !self_rst)
			|=> $stable(cnt_q);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("counter moved without a count clock edge");

	property p_bcd_digits;
		@(posedge sys_clk) disable iff (!rst_n)
		!IS_BIN |-> (cnt_q[3:0] <= pdt_pkg::DIGIT_MAX && cnt_q[7:4] <= TENS_MAX);
	endproperty
	a_bcd_digits: assert property (p_bcd_digits)
		else $error("decimal digit out of range");

	property p_carry;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_q == pdt_pkg::PDT_RUN && !IS_BIN)
			|-> carry_out == (cnt_q[7:4] == TENS_MAX);
	endproperty
	a_carry: assert property (p_carry)
		else $error("carry not high exactly for the last ten counts");

	property p_bus;
		@(posedge sys_clk) disable iff (!rst_n)
		state_q == pdt_pkg::PDT_RUN
			|-> sum_bus == (&(~sel_s | (cnt_q & OUT_MASK)));
	endproperty
	a_bus: assert property (p_bus)
		else $error("summed bus does not follow selected outputs");

	property p_tick_short;
		@(posedge sys_clk) disable iff (!rst_n)
		!tb_out_n |=> tb_out_n [*2];
	endproperty
	a_tick_short: assert property (p_tick_short)
		else $error("time base tick wider than one cycle");

	property p_tick_stop;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_q == pdt_pkg::PDT_IDLE && $past(state_q) == pdt_pkg::PDT_IDLE)
			|-> tb_out_n;
	endproperty
	a_tick_stop: assert property (p_tick_stop)
		else $error("time base ticking in reset state");

	c_start: cover property (@(posedge sys_clk) disable iff (!rst_n)
		state_q == pdt_pkg::PDT_IDLE ##1 state_q == pdt_pkg::PDT_RUN);
	c_self_rst: cover property (@(posedge sys_clk) disable iff (!rst_n) self_rst);
	c_carry: cover property (@(posedge sys_clk) disable iff (!rst_n) $fell(carry_out));
	c_wrap: cover property (@(posedge sys_clk) disable iff (!rst_n)
		state_q == pdt_pkg::PDT_RUN && cnt_evt && cnt_nxt == pdt_pkg::CNT_RST);

endmodule // pdt_top

// >>> pdt_src.sv
`timescale 1ns/1ps
// ****
// trigger, reset and count clock source
// ****
module pdt_src (
	input  wire logic sys_clk,
	output logic      trig_pin,
	output logic      reset_pin,
	output logic      ext_clk_pin
);
	initial begin
		trig_pin    = 1'b0;
		reset_pin   = 1'b0;
		ext_clk_pin = 1'b0;
	end

	task automatic edges(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask

	// rising control pulses, three clocks high then three low
	task automatic ctl(input logic t, input logic r);
		edges(1);
		trig_pin  = t;
		reset_pin = r;
		edges(3);
		trig_pin  = 1'b0;
		reset_pin = 1'b0;
		edges(3);
	endtask

	// one count clock pulse; its falling edge counts
	task automatic pulse();
		edges(1);
		ext_clk_pin = 1'b1;
		edges(3);
		ext_clk_pin = 1'b0;
		edges(6);
	endtask
endmodule // pdt_src

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
	// ****
	// signals and instances
	// ****
	localparam int TB = 4;
	localparam logic [7:0] SELS [6] = '{8'h20, 8'h31, 8'hff, 8'h99, 8'h01, 8'h01};
	localparam int         KMS  [6] = '{40, 60, 255, 100, 12, 1};
	localparam logic       FBS  [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
	logic        sys_clk;
	logic        rst_n;
	logic        ext_clk_sel;
	logic        fb_en;
	logic [7:0]  prog_sel;
	logic        trig_pin;
	logic        reset_pin;
	logic        ext_clk_pin;
	logic [7:0]  oe_b;
	logic [7:0]  oe_d;
	logic        sum_b;
	logic        sum_d;
	logic        car_b;
	logic        car_d;
	logic        tbn_b;
	logic        tbn_d;
	logic [7:0]  oe_s;
	logic        sum_s;
	logic        car_s;
	logic        tbn_s;
	logic [7:0]  cnt_b;
	logic [31:0] seed;
	int          failures;
	int          checks;

	pdt_src pdt_src_i (.sys_clk(sys_clk), .trig_pin(trig_pin), .reset_pin(reset_pin),
		.ext_clk_pin(ext_clk_pin));
	pdt_top #(.VARIANT(pdt_pkg::VAR_BIN), .TB_CYC(TB)) pdt_top_i (.sys_clk(sys_clk),
		.rst_n(rst_n), .trig_pin(trig_pin), .reset_pin(reset_pin), .ext_clk_pin(ext_clk_pin),
		.ext_clk_sel(ext_clk_sel), .fb_en(fb_en), .prog_sel(prog_sel), .cnt_o(cnt_b),
		.cnt_oe(oe_b), .sum_bus(sum_b), .carry_out(car_b), .tb_out_n(tbn_b));
	pdt_top #(.VARIANT(pdt_pkg::VAR_DEC99), .TB_CYC(TB)) pdt_top_i_dec (.sys_clk(sys_clk),
		.rst_n(rst_n), .trig_pin(trig_pin), .reset_pin(reset_pin), .ext_clk_pin(ext_clk_pin),
		.ext_clk_sel(ext_clk_sel), .fb_en(fb_en), .prog_sel(prog_sel), .cnt_o(),
		.cnt_oe(oe_d), .sum_bus(sum_d), .carry_out(car_d), .tb_out_n(tbn_d));
	pdt_top #(.VARIANT(pdt_pkg::VAR_DEC59), .TB_CYC(TB)) pdt_top_i_sixty (.sys_clk(sys_clk),
		.rst_n(rst_n), .trig_pin(trig_pin), .reset_pin(reset_pin), .ext_clk_pin(ext_clk_pin),
		.ext_clk_sel(ext_clk_sel), .fb_en(fb_en), .prog_sel(prog_sel), .cnt_o(),
		.cnt_oe(oe_s), .sum_bus(sum_s), .carry_out(car_s), .tb_out_n(tbn_s));

	// ****
	// helpers
	// ****
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic [7:0] bcd(input int k);
		return {4'((k % 100) / 10), 4'(k % 10)};
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic idle_chk();
		chk(oe_b | oe_d | oe_s | cnt_b, 8'h00, "idle outputs");
		chk({5'h0, tbn_s, sum_s, car_s}, 8'h07, "sixty idle levels");
		chk({2'h0, tbn_b, tbn_d, sum_b, sum_d, car_b, car_d}, 8'h3f, "idle levels");
	endtask

	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ****
	// external clock case: model all three counters pulse by pulse
	// ****
	task automatic run_case(input logic [7:0] sel, input logic fb, input int kmax,
		input logic both);
		logic [7:0] vb;
		logic [7:0] vd;
		logic       sb;
		logic       sd;
		logic [7:0] vs;
		logic       ss;
		sb = 1'b0;
		sd = 1'b0;
		ss = 1'b0;
		prog_sel = sel;
		fb_en = fb;
		ext_clk_sel = 1'b1;
		pdt_src_i.ctl(1'b1, both);
		for (int k = 0; k <= kmax; k++) begin
			if (k == 3 && !sb && !sd && !ss)
				pdt_src_i.ctl(1'b1, 1'b0);
			if (k > 0)
				pdt_src_i.pulse();
			vb = 8'(k);
			vd = bcd(k);
			sb = sb | (fb && (vb & sel) == sel);
			sd = sd | (fb && (vd & sel) == sel);
			chk(oe_b, sb ? 8'h00 : ~vb, "bin outputs");
			chk({5'h0, tbn_b, car_b, sum_b}, {5'h0, 2'h3, sb | ((vb & sel) == sel)},
				"bin levels");
			chk(oe_d, sd ? 8'h00 : ~vd, "dec outputs");
			chk({6'h0, car_d, sum_d}, {6'h0, sd | (vd[7:4] == 4'h9),
				sd | ((vd & sel) == sel)}, "dec levels");
			vs = bcd(k % 60);
			ss = ss | (fb && (vs & sel) == sel);
			chk(oe_s, ss ? 8'h00 : ~vs & 8'h7f, "sixty outputs");
			chk({6'h0, car_s, sum_s}, {6'h0, ss | (vs[7:4] == 4'h5),
				ss | ((vs & sel) == sel)}, "sixty levels");
		end
		pdt_src_i.ctl(1'b0, 1'b1);
		idle_chk();
	endtask

	// ****
	// internal time base case
	// ****
	task automatic tb_case(input logic [7:0] sel);
		int n;
		int lows;
		n = 0;
		lows = 0;
		prog_sel = sel;
		fb_en = 1'b1;
		ext_clk_sel = 1'b0;
		pdt_src_i.ctl(1'b1, 1'b0);
		while (sum_b !== 1'b1 && n < 4000) begin
			pdt_src_i.edges(1);
			n++;
			lows += (tbn_b === 1'b0);
		end
		chk(8'(lows), sel, "tick count");
		chk(8'(n >= sel * TB - 4 && n <= sel * TB + 4), 8'h01, "cycle span");
		pdt_src_i.edges(3);
		idle_chk();
	endtask

	// ****
	// clock, watchdog, sequence
	// ****
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	initial begin
		#1500000;
		failures++;
		report_and_stop();
	end

	initial begin
		rst_n = 1'b0;
		ext_clk_sel = 1'b1;
		fb_en = 1'b0;
		prog_sel = 8'h00;
		failures = 0;
		checks = 0;
		seed = 32'h2660;
		repeat (12) @(posedge sys_clk);
		#2 rst_n = 1'b1;
		pdt_src_i.edges(2);
		idle_chk();
		$display("test reset done");
		for (int i = 0; i < 10; i++) begin
			if (i < 6) begin
				run_case(SELS[i], FBS[i], KMS[i], i == 1);
			end else begin
				seed = lfsr(seed);
				run_case(seed[7:0] | 8'h01, seed[8], 60, seed[9]);
			end
			$display("test %0d done", i);
		end
		tb_case(8'h05);
		$display("test time base done");
		report_and_stop();
	end
endmodule // tb_top
